// File: pkg/coer_defs.svh
// Offsets, field positions, power-up values and frequency codes of the clock
// output enable block. Assumes inclusion by bare name from pkg/.
`ifndef COER_DEFS_SVH
`define COER_DEFS_SVH

`define COER_DEV_ADDR 7'h69
`define COER_NUM_REGS 7
`define COER_LAST_REG 3'h6

`define COER_REG_FREQ 3'h0
`define COER_REG_HOST 3'h1
`define COER_REG_BUS 3'h2
`define COER_REG_MEM_LO 3'h3
`define COER_REG_MEM_HI 3'h4
`define COER_REG_PERIPH 3'h5
`define COER_REG_SPARE 3'h6

`define COER_RST_FREQ 8'h00
`define COER_RST_HOST 8'hFF
`define COER_RST_BUS 8'h7F
`define COER_RST_MEM_LO 8'hFF
`define COER_RST_MEM_HI 8'h0F
`define COER_RST_PERIPH 8'h13
`define COER_RST_SPARE 8'h00

`define COER_TRI_BIT 0
`define COER_SOFT_EN_BIT 3
`define COER_SEL_HI 6
`define COER_SEL_LO 4
`define COER_BUS_FREE_BIT 6
`define COER_IRQ_BIT 4
`define COER_REF2_BIT 1
`define COER_REFERENCE_OUT_SECOND_BIT 0

`define COER_BYTE_BITS 4'h8
`define COER_CNT_DATA 2'h3

`define COER_KHZ_50000 17'h0C350
`define COER_KHZ_25000 17'h061A8
`define COER_KHZ_75000 17'h124F8
`define COER_KHZ_32000 17'h07D00
`define COER_KHZ_83300 17'h14564
`define COER_KHZ_41650 17'h0A2B2
`define COER_KHZ_68500 17'h10B94
`define COER_KHZ_34250 17'h085CA
`define COER_KHZ_33300 17'h08214
`define COER_KHZ_37500 17'h0927C
`define COER_KHZ_60000 17'h0EA60
`define COER_KHZ_30000 17'h07530
`define COER_KHZ_66800 17'h104F0
`define COER_KHZ_33400 17'h08278
`define COER_KHZ_14318 17'h037EE

`endif

// File: pkg/coer_pkg.sv
// Types shared by the clock output enable block.
// Assumes nothing of its surroundings.
`default_nettype none
package coer_pkg;

    typedef struct packed {
        logic irq_controller_clk_out;
        logic reference_out_second;
        logic reference_out_first;
        logic [11:0] mem_clk_out;
        logic free_running_bus_clk;
        logic [5:0] bus_clk_out;
        logic [3:0] host_clk_out;
    } coer_clk_vec_t;

    typedef struct packed {
        logic [16:0] host_khz;
        logic [16:0] mem_khz;
        logic [16:0] bus_khz;
        logic [16:0] ref_khz;
    } coer_freq_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_RACK = 3'h2,
        ST_TX = 3'h3,
        ST_TACK = 3'h4,
        ST_IGNORE = 3'h5
    } coer_ser_st_t;

endpackage
`default_nettype wire

// File: src/coer_gate.sv
// Glitch-free gate for one clock output.
// Assumes src is a clock level sampled on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module coer_gate (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Power-up reset, active low
    input wire logic src, // Free clock level
    input wire logic en, // Enable from register bit
    output logic out // Gated clock level
);
    logic run_r;
    logic run_nxt;
    logic out_r;
    logic out_nxt;

    // Run state may change only while the source is low, so no pulse is cut
    always_comb begin
        run_nxt = run_r;
        if (!src) begin
            run_nxt = en;
        end
        out_nxt = src & run_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            run_r <= 1'b0;
            out_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            out_r <= out_nxt;
        end
    end

    assign out = out_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_change_low: assert property ($changed(run_r) |-> !$past(src))
        else $error("run state changed while source high");
    a_stopped_low: assert property (!run_r |=> !out_r)
        else $error("stopped output not low");
    a_runs_enabled: assert property ((en && !src) ##1 (src && en) |=> out_r)
        else $error("enabled output did not follow source");
endmodule
`default_nettype wire

// File: src/coer_top.sv
// Register file and serial slave of the clock output enable block.
// Assumes scl_in/sda_in are synchronous to clk_sys and clock sources are levels.
`timescale 1ns/1ps
`default_nettype none
`include "coer_defs.svh"

module coer_top (
    input wire logic clk_sys, // System clock, 125 MHz
    input wire logic rstn, // Power-up reset, active low
    input wire logic scl_in, // Serial clock level
    input wire logic sda_in, // Serial data wire level
    output logic sda_out, // Serial data drive value, always low
    output logic sda_oe, // Serial data pulled low when high
    input wire logic [2:0] hw_freq_sel, // Strap frequency select
    input wire logic host_src, // Free host clock level
    input wire logic bus_src, // Free bus clock level
    input wire logic ref_src, // Free reference clock level
    output coer_pkg::coer_clk_vec_t clk_out, // Gated clock levels
    output logic clk_oe, // Clock pins driven when high
    output coer_pkg::coer_freq_t freq_out // Selected frequencies in kHz
);
    logic [7:0] regs_r [`COER_NUM_REGS];
    logic [7:0] regs_nxt [`COER_NUM_REGS];
    coer_pkg::coer_ser_st_t st_r;
    coer_pkg::coer_ser_st_t st_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [3:0] bits_r;
    logic [3:0] bits_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic [2:0] ptr_r;
    logic [2:0] ptr_nxt;
    logic rd_r;
    logic rd_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic sda_out_r;
    logic scl_p_r;
    logic sda_p_r;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] rd_byte;
    logic [2:0] strap_r;
    logic [2:0] strap_nxt;
    logic strap_done_r;
    logic strap_done_nxt;
    logic [2:0] sel;
    coer_pkg::coer_freq_t freq_r;
    coer_pkg::coer_freq_t freq_nxt;
    logic clk_oe_r;
    logic clk_oe_nxt;
    coer_pkg::coer_clk_vec_t en_vec;
    coer_pkg::coer_clk_vec_t src_vec;
    coer_pkg::coer_clk_vec_t out_vec;

    function automatic coer_pkg::coer_freq_t decode(input logic [2:0] code);
        coer_pkg::coer_freq_t f;
        f.ref_khz = `COER_KHZ_14318;
        case (code)
            3'h0: begin
                f.host_khz = `COER_KHZ_50000;
                f.bus_khz = `COER_KHZ_25000;
            end
            3'h1: begin
                f.host_khz = `COER_KHZ_75000;
                f.bus_khz = `COER_KHZ_32000;
            end
            3'h2: begin
                f.host_khz = `COER_KHZ_83300;
                f.bus_khz = `COER_KHZ_41650;
            end
            3'h3: begin
                f.host_khz = `COER_KHZ_68500;
                f.bus_khz = `COER_KHZ_34250;
            end
            3'h4: begin
                f.host_khz = `COER_KHZ_83300;
                f.bus_khz = `COER_KHZ_33300;
            end
            3'h5: begin
                f.host_khz = `COER_KHZ_75000;
                f.bus_khz = `COER_KHZ_37500;
            end
            3'h6: begin
                f.host_khz = `COER_KHZ_60000;
                f.bus_khz = `COER_KHZ_30000;
            end
            default: begin
                f.host_khz = `COER_KHZ_66800;
                f.bus_khz = `COER_KHZ_33400;
            end
        endcase
        f.mem_khz = f.host_khz;
        return f;
    endfunction

    // Serial pins are sampled once to find edges and bus conditions
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
            sda_out_r <= 1'b0;
        end else begin
            scl_p_r <= scl_in;
            sda_p_r <= sda_in;
            sda_out_r <= 1'b0;
        end
    end

    assign scl_rise = scl_in & ~scl_p_r;
    assign scl_fall = ~scl_in & scl_p_r;
    assign start_cond = scl_in & scl_p_r & sda_p_r & ~sda_in;
    assign stop_cond = scl_in & scl_p_r & ~sda_p_r & sda_in;
    // Beyond the last register reads return zero
    assign rd_byte = (ptr_r <= `COER_LAST_REG) ? regs_r[ptr_r] : 8'h00;

    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        bits_nxt = bits_r;
        cnt_nxt = cnt_r;
        ptr_nxt = ptr_r;
        rd_nxt = rd_r;
        sda_oe_nxt = sda_oe_r;
        regs_nxt = regs_r;
        if (start_cond) begin
            st_nxt = coer_pkg::ST_RX;
            bits_nxt = 4'h0;
            cnt_nxt = 2'h0;
            ptr_nxt = 3'h0;
            sda_oe_nxt = 1'b0;
        end else if (stop_cond) begin
            st_nxt = coer_pkg::ST_IDLE;
            sda_oe_nxt = 1'b0;
        end else begin
            case (st_r)
                coer_pkg::ST_IDLE: begin
                    st_nxt = coer_pkg::ST_IDLE;
                end
                coer_pkg::ST_RX: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_in};
                        bits_nxt = 4'(bits_r + 4'h1);
                    end else if (scl_fall && bits_r == `COER_BYTE_BITS) begin
                        bits_nxt = 4'h0;
                        if (cnt_r != `COER_CNT_DATA) begin
                            cnt_nxt = 2'(cnt_r + 2'h1);
                        end
                        if (cnt_r == 2'h0) begin
                            if (sh_r[7:1] == `COER_DEV_ADDR) begin
                                st_nxt = coer_pkg::ST_RACK;
                                sda_oe_nxt = 1'b1;
                                rd_nxt = sh_r[0];
                            end else begin
                                st_nxt = coer_pkg::ST_IGNORE;
                            end
                        end else begin
                            // Command and count bytes are acked and dropped
                            st_nxt = coer_pkg::ST_RACK;
                            sda_oe_nxt = 1'b1;
                            if (cnt_r == `COER_CNT_DATA && ptr_r <= `COER_LAST_REG) begin
                                regs_nxt[ptr_r] = sh_r;
                                ptr_nxt = 3'(ptr_r + 3'h1);
                            end
                        end
                    end
                end
                coer_pkg::ST_RACK: begin
                    if (scl_fall) begin
                        if (rd_r) begin
                            st_nxt = coer_pkg::ST_TX;
                            sh_nxt = rd_byte;
                            sda_oe_nxt = ~rd_byte[7];
                            bits_nxt = 4'h1;
                            if (ptr_r <= `COER_LAST_REG) begin
                                ptr_nxt = 3'(ptr_r + 3'h1);
                            end
                        end else begin
                            st_nxt = coer_pkg::ST_RX;
                            sda_oe_nxt = 1'b0;
                        end
                    end
                end
                coer_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bits_r == `COER_BYTE_BITS) begin
                            st_nxt = coer_pkg::ST_TACK;
                            sda_oe_nxt = 1'b0;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            sda_oe_nxt = ~sh_r[6];
                            bits_nxt = 4'(bits_r + 4'h1);
                        end
                    end
                end
                coer_pkg::ST_TACK: begin
                    if (scl_rise) begin
                        sh_nxt[0] = sda_in;
                    end else if (scl_fall) begin
                        if (!sh_r[0]) begin
                            st_nxt = coer_pkg::ST_TX;
                            sh_nxt = rd_byte;
                            sda_oe_nxt = ~rd_byte[7];
                            bits_nxt = 4'h1;
                            if (ptr_r <= `COER_LAST_REG) begin
                                ptr_nxt = 3'(ptr_r + 3'h1);
                            end
                        end else begin
                            st_nxt = coer_pkg::ST_IGNORE;
                        end
                    end
                end
                coer_pkg::ST_IGNORE: begin
                    st_nxt = coer_pkg::ST_IGNORE;
                end
                default: begin
                    st_nxt = coer_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_r <= coer_pkg::ST_IDLE;
            sh_r <= 8'h00;
            bits_r <= 4'h0;
            cnt_r <= 2'h0;
            ptr_r <= 3'h0;
            rd_r <= 1'b0;
            sda_oe_r <= 1'b0;
            regs_r[`COER_REG_FREQ] <= `COER_RST_FREQ;
            regs_r[`COER_REG_HOST] <= `COER_RST_HOST;
            regs_r[`COER_REG_BUS] <= `COER_RST_BUS;
            regs_r[`COER_REG_MEM_LO] <= `COER_RST_MEM_LO;
            regs_r[`COER_REG_MEM_HI] <= `COER_RST_MEM_HI;
            regs_r[`COER_REG_PERIPH] <= `COER_RST_PERIPH;
            regs_r[`COER_REG_SPARE] <= `COER_RST_SPARE;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            bits_r <= bits_nxt;
            cnt_r <= cnt_nxt;
            ptr_r <= ptr_nxt;
            rd_r <= rd_nxt;
            sda_oe_r <= sda_oe_nxt;
            regs_r <= regs_nxt;
        end
    end

    // Strap caught once after reset release; frequency and pin mode registered
    always_comb begin
        strap_nxt = strap_r;
        strap_done_nxt = 1'b1;
        if (!strap_done_r) begin
            strap_nxt = hw_freq_sel;
        end
        sel = regs_r[`COER_REG_FREQ][`COER_SOFT_EN_BIT] ?
              regs_r[`COER_REG_FREQ][`COER_SEL_HI:`COER_SEL_LO] : strap_r;
        freq_nxt = decode(sel);
        clk_oe_nxt = ~regs_r[`COER_REG_FREQ][`COER_TRI_BIT];
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            strap_r <= 3'h0;
            strap_done_r <= 1'b0;
            freq_r <= '0;
            clk_oe_r <= 1'b0;
        end else begin
            strap_r <= strap_nxt;
            strap_done_r <= strap_done_nxt;
            freq_r <= freq_nxt;
            clk_oe_r <= clk_oe_nxt;
        end
    end

    // Enable map; reserved bits and the spare byte reach no output
    always_comb begin
        en_vec.host_clk_out = regs_r[`COER_REG_HOST][3:0];
        en_vec.bus_clk_out = regs_r[`COER_REG_BUS][5:0];
        en_vec.free_running_bus_clk = regs_r[`COER_REG_BUS][`COER_BUS_FREE_BIT];
        en_vec.mem_clk_out = {regs_r[`COER_REG_MEM_HI][3:0],
                              regs_r[`COER_REG_MEM_LO]};
        en_vec.irq_controller_clk_out = regs_r[`COER_REG_PERIPH][`COER_IRQ_BIT];
        en_vec.reference_out_second = regs_r[`COER_REG_PERIPH][`COER_REF2_BIT];
        en_vec.reference_out_first = regs_r[`COER_REG_PERIPH][`COER_REFERENCE_OUT_SECOND_BIT];
        src_vec.host_clk_out = {4{host_src}};
        src_vec.mem_clk_out = {12{host_src}};
        src_vec.bus_clk_out = {6{bus_src}};
        src_vec.free_running_bus_clk = bus_src;
        src_vec.irq_controller_clk_out = ref_src;
        src_vec.reference_out_second = ref_src;
        src_vec.reference_out_first = ref_src;
    end

    genvar gi;
    generate
        for (gi = 0; gi < $bits(coer_pkg::coer_clk_vec_t); gi++) begin : g_gate
            coer_gate u_gate (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .src(src_vec[gi]),
                .en(en_vec[gi]),
                .out(out_vec[gi])
            );
        end
    endgenerate

    assign clk_out = out_vec;
    assign clk_oe = clk_oe_r;
    assign freq_out = freq_r;
    assign sda_out = sda_out_r;
    assign sda_oe = sda_oe_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_addr_match;
        st_r == coer_pkg::ST_RX && scl_fall && bits_r == 4'h8 && cnt_r == 2'h0
            && sh_r[7:1] == 7'h69 && !start_cond && !stop_cond;
    endsequence
    sequence s_data_byte;
        st_r == coer_pkg::ST_RX && scl_fall && bits_r == 4'h8 && cnt_r == 2'h3
            && ptr_r <= 3'h6 && !start_cond && !stop_cond;
    endsequence
    sequence s_hdr_byte;
        st_r == coer_pkg::ST_RX && scl_fall && bits_r == 4'h8 && cnt_r != 2'h0
            && cnt_r != 2'h3 && !start_cond && !stop_cond;
    endsequence

    a_addr_ack: assert property (s_addr_match |=> sda_oe_r && st_r == coer_pkg::ST_RACK)
        else $error("address byte not acknowledged");
    a_hdr_ignored: assert property (s_hdr_byte |=> sda_oe_r && $stable({regs_r[6], regs_r[5],
        regs_r[4], regs_r[3], regs_r[2], regs_r[1], regs_r[0]}))
        else $error("command or count byte altered registers");
    a_write_store: assert property (s_data_byte |=> regs_r[$past(ptr_r)] == $past(sh_r))
        else $error("data byte not stored");
    a_reset_values: assert property (!$past(rstn) |-> regs_r[1] == 8'hFF && regs_r[2] == 8'h7F
        && regs_r[3] == 8'hFF && regs_r[4] == 8'h0F && regs_r[5] == 8'h13)
        else $error("power-up register values wrong");
    a_tri_float: assert property (regs_r[0][0] |=> !clk_oe_r)
        else $error("tristate bit did not float outputs");
    a_soft_decode: assert property (regs_r[0][3] && regs_r[0][6:4] == 3'h2 |=> freq_r.host_khz
        == 17'h14564 && freq_r.bus_khz == 17'h0A2B2)
        else $error("software select decode wrong");
    a_strap_decode: assert property (!regs_r[0][3] && strap_r == 3'h2 |=> freq_r.bus_khz
        == 17'h0A2B2 && freq_r.host_khz == 17'h14564)
        else $error("strap select not used");
    a_mem_follows: assert property (freq_r.mem_khz == freq_r.host_khz
        && (!$past(rstn) || freq_r.ref_khz == 17'h037EE))
        else $error("memory or reference frequency wrong");
    a_host_stop: assert property (!regs_r[1][0] [*3] |=> !clk_out.host_clk_out[0])
        else $error("disabled host output toggled");
endmodule
`default_nettype wire

// File: tb/coer_bus_master.sv
// Two-wire bus master model that writes and reads the enable registers.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module coer_bus_master (
    input wire logic clk_sys, // System clock
    input wire logic sda_in, // Resolved data wire level
    output logic scl, // Serial clock level
    output logic sda_low // Pulls the data wire low when high
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Data changes only while scl is low; the wire is sampled late in the high phase
    task automatic bit_io(input logic b, output logic seen);
        sda_low <= ~b;
        hold(2);
        scl <= 1'b1;
        hold(3);
        @(negedge clk_sys) seen = sda_in;
        @(posedge clk_sys) scl <= 1'b0;
        hold(2);
    endtask

    task automatic start_cond;
        sda_low <= 1'b0;
        hold(2);
        scl <= 1'b1;
        hold(4);
        sda_low <= 1'b1;
        hold(4);
        scl <= 1'b0;
        hold(2);
    endtask

    task automatic stop_cond;
        sda_low <= 1'b1;
        hold(2);
        scl <= 1'b1;
        hold(4);
        sda_low <= 1'b0;
        hold(4);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask

    task automatic write_frame(input logic [6:0] addr, input logic [7:0] d [7], input int n,
                               output logic ok);
        logic a;
        start_cond();
        wr_byte({addr, 1'b0}, ok);
        wr_byte(8'h00, a);
        ok &= a;
        wr_byte(8'h07, a);
        ok &= a;
        for (int i = 0; i < n; i++) begin
            wr_byte(d[i], a);
            ok &= a;
        end
        stop_cond();
    endtask

    task automatic read_frame(input logic [6:0] addr, input int n, output logic [7:0] d [7],
                              output logic ok);
        start_cond();
        wr_byte({addr, 1'b1}, ok);
        for (int i = 0; i < n; i++) begin
            rd_byte(i == n - 1, d[i]);
        end
        stop_cond();
    endtask
endmodule
`default_nettype wire

// File: tb/test_clock_output_enable_regs.sv
// Self-checking bench for the clock output enable registers.
// Assumes the bus master model and a 125 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module test_clock_output_enable_regs;
    logic clk_sys, rstn, scl, m_low, sda_oe, sda_out, clk_oe, ack, src;
    logic [2:0] hw_sel;
    logic [1:0] src_cnt;
    coer_pkg::coer_clk_vec_t clk_out;
    coer_pkg::coer_freq_t freq_out;
    logic [7:0] wr_buf [7];
    logic [7:0] rd_buf [7];
    logic [7:0] pu [7] = '{8'h00, 8'hFF, 8'h7F, 8'hFF, 8'h0F, 8'h13, 8'h00};
    logic [16:0] host_tab [8] = '{17'h0C350, 17'h124F8, 17'h14564, 17'h10B94,
                                  17'h14564, 17'h124F8, 17'h0EA60, 17'h104F0};
    logic [16:0] bus_tab [8] = '{17'h061A8, 17'h07D00, 17'h0A2B2, 17'h085CA,
                                 17'h08214, 17'h0927C, 17'h07530, 17'h08278};
    int errors, checks_done, cycles, hi_cnt;
    wire sda;

    assign sda = ~(m_low | sda_oe);
    assign src = src_cnt[1];

    coer_bus_master i_mst (.clk_sys(clk_sys), .sda_in(sda), .scl(scl), .sda_low(m_low));

    coer_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .hw_freq_sel(hw_sel), .host_src(src),
        .bus_src(!src), .ref_src(!src), .clk_out(clk_out), .clk_oe(clk_oe),
        .freq_out(freq_out));

    task automatic check(input string what, input logic [67:0] seen, input logic [67:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Outputs follow their sources one cycle later; host and memory run on src, the
    // bus and reference groups on its inverse, so a swapped source shows up here
    task automatic check_outs(input logic [25:0] exp);
        repeat (8) @(posedge clk_sys);
        for (int v = 1; v >= 0; v--) begin
            do @(negedge clk_sys); while (src !== v[0]);
            @(posedge clk_sys);
            #1 check("clk_out", clk_out, exp & (v ? 26'h07FF80F : 26'h38007F0));
        end
    endtask

    task automatic write_r0(input logic [7:0] r0, input logic [6:0] addr);
        wr_buf[0] = r0;
        i_mst.write_frame(addr, wr_buf, 1, ack);
        repeat (4) @(posedge clk_sys);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        src_cnt <= src_cnt + 2'h1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    // Every high pulse of host_clk_out[0] keeps the full two-cycle width
    always @(posedge clk_sys) begin
        if (rstn && clk_out.host_clk_out[0] === 1'b1) begin
            hi_cnt <= hi_cnt + 1;
        end else begin
            if (hi_cnt != 0) check("host0 pulse", hi_cnt, 2);
            hi_cnt <= 0;
        end
    end

    initial begin
        rstn = 1'b0;
        hw_sel = 3'h2;
        src_cnt = 2'h0;
        cycles = 0;
        hi_cnt = 0;
        errors = 0;
        checks_done = 0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("clk_oe", clk_oe, 1'b1);
        check("strap freq", freq_out, {host_tab[2], host_tab[2], bus_tab[2], 17'h037EE});
        check("sda_out", sda_out, 1'b0);
        i_mst.read_frame(7'h69, 7, rd_buf, ack);
        check("read ack", ack, 1'b1);
        for (int i = 0; i < 7; i++) check("power-up", rd_buf[i], pu[i]);
        check_outs(26'h3FFFFFF);
        wr_buf = '{8'h08, 8'hFA, 8'hAA, 8'h55, 8'hFA, 8'hEE, 8'hA5};
        i_mst.write_frame(7'h69, wr_buf, 7, ack);
        check("write ack", ack, 1'b1);
        check_outs({wr_buf[5][4], wr_buf[5][1:0], wr_buf[4][3:0], wr_buf[3],
                    wr_buf[2][6:0], wr_buf[1][3:0]});
        i_mst.read_frame(7'h69, 7, rd_buf, ack);
        for (int i = 0; i < 7; i++) check("read back", rd_buf[i], wr_buf[i]);
        wr_buf = '{8'h08, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        i_mst.write_frame(7'h69, wr_buf, 6, ack);
        check_outs(26'h3FFFFFF);
        for (int c = 0; c < 8; c++) begin
            write_r0({1'b0, c[2:0], 4'h8}, 7'h69);
            check("soft freq", freq_out, {host_tab[c], host_tab[c], bus_tab[c], 17'h037EE});
        end
        write_r0(8'h70, 7'h69);
        check("hw freq", freq_out, {host_tab[2], host_tab[2], bus_tab[2], 17'h037EE});
        write_r0(8'h01, 7'h69);
        check("tristate", clk_oe, 1'b0);
        write_r0(8'h00, 7'h69);
        check("normal", clk_oe, 1'b1);
        write_r0(8'h01, 7'h2A);
        check("foreign ack", ack, 1'b0);
        check("foreign write", clk_oe, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
